// ===== ierr_pkg.sv
// Constants for the internal error injection test block.
// Assumes a single 250 MHz register clock and an AXI4-Lite master.
//
// Behaviour
// - Writing a one to a defined test bit sets the same status bit.
// - Every defined test bit reads back as zero.
// - Bits 0-2 inject ingress posted, non-posted, completion time-outs.
// - Bits 4, 5, 6 inject egress time-outs likewise; bit 3 is reserved.
// - Bits 7 to 10 inject ingress data and control single/double errors.
// - Bits 11 to 14 inject egress data and control single/double errors.
// - Bit 15 injects the end-to-end data path parity error.
// - Bit 16 injects the unreliable link detected condition.
// - Bits 17, 18 inject replay ctrl single/double; 31:19 reserved.
// - Unmasked status: severity 1 is uncorrectable, 0 is correctable.
package ierr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] inject_test_off = 12'h490;
  localparam logic [11:0] err_status_off = 12'h494;
  localparam logic [11:0] err_mask_off = 12'h498;
  localparam logic [11:0] err_severity_off = 12'h49c;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int err_bits = 19;
  localparam logic [31:0] defined_mask = 32'h0007_fff7;
  localparam logic [31:0] status_reset = 32'h0000_0000;
  localparam logic [31:0] mask_reset = 32'h0000_0000;
  localparam logic [31:0] severity_reset = 32'h0004_d500;

  localparam int ingress_posted_timeout = 0;
  localparam int ingress_nonposted_timeout = 1;
  localparam int ingress_completion_timeout = 2;
  localparam int egress_posted_timeout = 4;
  localparam int egress_nonposted_timeout = 5;
  localparam int egress_completion_timeout = 6;
  localparam int ingress_data_single_err = 7;
  localparam int ingress_data_double_err = 8;
  localparam int ingress_ctrl_single_err = 9;
  localparam int ingress_ctrl_double_err = 10;
  localparam int egress_data_single_err = 11;
  localparam int egress_data_double_err = 12;
  localparam int egress_ctrl_single_err = 13;
  localparam int egress_ctrl_double_err = 14;
  localparam int end_to_end_parity_err = 15;
  localparam int unreliable_link_flag = 16;
  localparam int replay_ctrl_single_err = 17;
  localparam int replay_ctrl_double_err = 18;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

endpackage : ierr_pkg

// ===== ierr_status_bank.sv
// Sticky internal error status with injection, mask and severity split.
// Assumes detect and inject inputs are on sys_clk.
`timescale 1ns/1ps
module ierr_status_bank
  import ierr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Sources
  input wire logic [31:0] detect,
  input wire logic [31:0] inject,
  input wire logic [31:0] clear,
  // Controls
  input wire logic [31:0] mask,
  input wire logic [31:0] severity,
  // Results
  output logic [31:0] status_q,
  output logic uncorr_d,
  output logic corr_d
);

  logic [31:0] set_w;
  logic [31:0] live_w;
  logic [31:0] status_d;

  // Injection merges with real detection, so both paths look identical
  assign set_w = (detect | inject) & defined_mask;
  // Set wins over a clear in the same cycle
  assign status_d = (status_q & ~clear) | set_w;
  assign live_w = status_q & ~mask;
  assign uncorr_d = |(live_w & severity);
  assign corr_d = |(live_w & ~severity);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= status_reset;
    end else begin
      status_q <= status_d;
    end
  end

endmodule : ierr_status_bank

// ===== ierr_inject_top.sv
// AXI4-Lite slave holding the error injection test, status, mask and
// severity registers. Assumes one write and one read in flight at most.
`timescale 1ns/1ps
module ierr_inject_top
  import ierr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Real error detectors
  input wire logic [31:0] err_detect,
  // Reporting
  output logic uncorr_err_q,
  output logic corr_err_q,
  output logic irq_q
);

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  logic aw_have_q;
  logic [11:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take_w;
  logic w_take_w;
  logic wr_fire_w;

  assign aw_take_w = s_axi_awvalid & s_axi_awready;
  assign w_take_w = s_axi_wvalid & s_axi_wready;
  assign wr_fire_w = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~aw_take_w & ~s_axi_bvalid;
      if (aw_take_w) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire_w) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_have_q & ~w_take_w & ~s_axi_bvalid;
      if (w_take_w) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire_w) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  logic [31:0] wbits_w;
  logic wr_test_w;
  logic wr_sts_w;
  logic wr_mask_w;
  logic wr_sev_w;
  logic wr_hit_w;
  logic [31:0] inject_w;
  logic [31:0] clear_w;
  logic [31:0] mask_q;
  logic [31:0] sev_q;
  logic [31:0] status_w;
  logic uncorr_w;
  logic corr_w;

  assign wbits_w = w_data_q & strb_mask(w_strb_q);
  assign wr_test_w = wr_fire_w & (aw_addr_q[11:2] == inject_test_off[11:2]);
  assign wr_sts_w = wr_fire_w & (aw_addr_q[11:2] == err_status_off[11:2]);
  assign wr_mask_w = wr_fire_w & (aw_addr_q[11:2] == err_mask_off[11:2]);
  assign wr_sev_w = wr_fire_w & (aw_addr_q[11:2] == err_severity_off[11:2]);
  assign wr_hit_w = wr_test_w | wr_sts_w | wr_mask_w | wr_sev_w;
  // Test register stores nothing: a one pulses a set, a zero does nothing
  assign inject_w = wr_test_w ? (wbits_w & defined_mask) : 32'h0000_0000;
  assign clear_w = wr_sts_w ? wbits_w : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= mask_reset;
      sev_q <= severity_reset;
    end else begin
      if (wr_mask_w) begin
        mask_q <= (mask_q & ~strb_mask(w_strb_q)) | (wbits_w & defined_mask);
      end
      if (wr_sev_w) begin
        sev_q <= (sev_q & ~strb_mask(w_strb_q)) | (wbits_w & defined_mask);
      end
    end
  end

  ierr_status_bank u_bank (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .detect(err_detect),
    .inject(inject_w),
    .clear(clear_w),
    .mask(mask_q),
    .severity(sev_q),
    .status_q(status_w),
    .uncorr_d(uncorr_w),
    .corr_d(corr_w)
  );

  // ****************************************************************
  // Write response and reporting outputs
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
      uncorr_err_q <= 1'b0;
      corr_err_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (wr_fire_w) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit_w ? resp_okay : resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      uncorr_err_q <= uncorr_w;
      corr_err_q <= corr_w;
      irq_q <= uncorr_w | corr_w;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic ar_take_w;
  logic [9:0] rword_w;
  logic [31:0] rmux_w;
  logic rhit_w;

  assign ar_take_w = s_axi_arvalid & s_axi_arready;
  assign rword_w = s_axi_araddr[11:2];
  // Test register always reads zero, reserved bits included
  assign rmux_w =
    (rword_w == err_status_off[11:2]) ? status_w :
    (rword_w == err_mask_off[11:2]) ? mask_q :
    (rword_w == err_severity_off[11:2]) ? sev_q :
    32'h0000_0000;
  assign rhit_w = (rword_w == inject_test_off[11:2]) |
                  (rword_w == err_status_off[11:2]) |
                  (rword_w == err_mask_off[11:2]) |
                  (rword_w == err_severity_off[11:2]);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take_w;
      if (ar_take_w) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux_w;
        s_axi_rresp <= rhit_w ? resp_okay : resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : ierr_inject_top

// ===== ierr_inject_asserts.sv
// Checker for the error injection register block.
// Assumes a bind onto ierr_inject_top, one sys_clk domain.
`timescale 1ns/1ps
module ierr_inject_asserts
  import ierr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reporting
  input wire logic uncorr_err_q,
  input wire logic corr_err_q,
  input wire logic irq_q
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [11:0] ar_q;
  logic mapped;
  // Read address kept so data can be judged by the place it came from
  assign mapped = ar_q[11:2] inside {inject_test_off[11:2],
    err_status_off[11:2], err_mask_off[11:2], err_severity_off[11:2]};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) ar_q <= 12'h0;
    else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  property p_irq; irq_q == (uncorr_err_q | corr_err_q); endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_tst0; s_axi_rvalid && ar_q[11:2] == inject_test_off[11:2]
    |-> s_axi_rdata == 32'h0 && s_axi_rresp == resp_okay; endproperty
  property p_unmap; s_axi_rvalid && !mapped
    |-> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0; endproperty
  a_irq: assert property (p_irq)
    else $error("irq not the or of both reports");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  a_arblk: assert property (p_arblk) else $error("read taken while busy");
  a_awblk: assert property (p_awblk) else $error("write taken while busy");
  a_rlat: assert property (p_rlat) else $error("read answer late");
  a_blat: assert property (p_blat) else $error("write answer late");
  a_tst0: assert property (p_tst0)
    else $error("test register read not zero");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not refused");
  c_irq: cover property (irq_q);
  c_uncorr: cover property (uncorr_err_q);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == resp_slverr);
endmodule : ierr_inject_asserts

bind ierr_inject_top ierr_inject_asserts chk_u (.sys_clk, .rst_b,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .uncorr_err_q, .corr_err_q, .irq_q);

// ===== internal_error_injection_test_test.sv
// Self-checking bench for the error injection register block.
// Assumes the checker file is compiled before it and binds itself.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %0t %h %h", $time, (a), (e)); end end
module internal_error_injection_test_test
  import ierr_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, uncorr_err_q, corr_err_q, irq_q;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, err_detect = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int mismatches = 0, checks = 0, cyc = 0;
  ierr_inject_top dut_u (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .err_detect,
    .uncorr_err_q, .corr_err_q, .irq_q);
  // ****
  // Bus tasks and scenarios
  // ****
  always #2 sys_clk = ~sys_clk;
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic t_reset();
    rd(inject_test_off);
    `CHK(d, 32'h0)
    `CHK(r, resp_okay)
    rd(err_status_off);
    `CHK(d, status_reset)
    rd(err_mask_off);
    `CHK(d, mask_reset)
    rd(err_severity_off);
    `CHK(d, severity_reset)
  endtask : t_reset
  task automatic t_walk();
    logic [31:0] b;
    for (int i = 0; i < 32; i++) begin
      b = 32'h1 << i;
      wr(inject_test_off, b);
      `CHK(r, resp_okay)
      rd(err_status_off);
      `CHK(d, b & defined_mask)
      `CHK(d[i], defined_mask[i])
      rd(inject_test_off);
      `CHK(d, 32'h0)
      #1;
      `CHK(uncorr_err_q, defined_mask[i] & severity_reset[i])
      `CHK(corr_err_q, defined_mask[i] & ~severity_reset[i])
      `CHK(irq_q, defined_mask[i])
      wr(err_status_off, b);
      rd(err_status_off);
      `CHK(d, 32'h0)
    end
  endtask : t_walk
  task automatic t_mask();
    wr(err_mask_off, 32'h1);
    wr(inject_test_off, 32'h1);
    #1;
    `CHK(irq_q, 1'b0)
    wr(err_mask_off, 32'h0);
    wr(inject_test_off, 32'h0);
    rd(err_status_off);
    `CHK(d, 32'h1)
    #1;
    `CHK(corr_err_q, 1'b1)
    wr(err_severity_off, 32'h1);
    rd(err_severity_off);
    `CHK(d, 32'h1)
    #1;
    `CHK(uncorr_err_q, 1'b1)
    wr(err_status_off, 32'h1);
    wr(err_severity_off, severity_reset);
    // Byte strobes: only lane 1 of the mask may change
    @(posedge sys_clk);
    s_axi_wstrb <= 4'h2;
    wr(err_mask_off, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    rd(err_mask_off);
    `CHK(d, 32'h0000_ff00)
    wr(err_mask_off, mask_reset);
  endtask : t_mask
  task automatic t_detect();
    @(posedge sys_clk);
    err_detect <= 32'h100;
    @(posedge sys_clk);
    err_detect <= 32'h0;
    rd(err_status_off);
    `CHK(d, 32'h100)
    #1;
    `CHK(uncorr_err_q, 1'b1)
    wr(12'h4a0, 32'hffffffff);
    `CHK(r, resp_slverr)
    rd(12'h4a0);
    `CHK(r, resp_slverr)
    `CHK(d, 32'h0)
  endtask : t_detect
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_walk();
    t_mask();
    t_detect();
    end_of_test();
  end
endmodule : internal_error_injection_test_test
